/* hw/pdw_pkg.sv */
// Purpose: Shared constants and types of the power down wake-up controller
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes:   Offsets are byte addresses, one aligned word per register
`default_nettype none

package pdw_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PCTL = 8'h00;
    localparam logic [7:0] ADDR_WCTL = 8'h04;
    localparam logic [7:0] ADDR_PORT = 8'h08;
    localparam logic [7:0] ADDR_ALT = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PDE_BIT = 1;
    localparam int WAKE_EN_BIT = 0;
    localparam int SRC_SEL_BIT = 1;
    localparam int ALE_OFF_BIT = 2;
    localparam logic [7:0] PCTL_MASK = 8'h9F;
    localparam logic [7:0] WCTL_MASK = 8'h07;
    localparam logic [7:0] PCTL_RST = 8'h00;
    localparam logic [7:0] WCTL_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [7:0] ALT_RST = 8'h00;
    localparam logic [15:0] WAKE_VECTOR = 16'h007B;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int OSC_STABLE_MS = 10;
    localparam int PLL_LOCK_MS = 1;
    localparam int OSC_CYCLES = OSC_STABLE_MS * CLK_FREQ_KHZ;
    localparam int PLL_CYCLES = PLL_LOCK_MS * CLK_FREQ_KHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_PDOWN = 3'h1,
        ST_OSC_WAIT = 3'h2,
        ST_PLL_WAIT = 3'h3,
        ST_WAKE_IRQ = 3'h4,
        ST_WAKE_ISR = 3'h5
    } pdw_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pdw_apb_req_t;

endpackage : pdw_pkg

`default_nettype wire

/* hw/pdw_top.sv */
// Purpose: Power down entry, frozen pins and pin wake-up sequencing
// Assumes: Core stops on o_core_clk_en low; RAM kept outside this block
// Notes:   Oscillator and PLL settling are modelled by counters
//
// Function
// - Power down stops oscillator and PLL, halts all, keeps RAM and registers.
// - Latch-driven port pins keep showing their port register values.
// - Alternate-function pins hold their levels from the entering instruction.
// - Address latch enable stays high in power down unless disabled.
// - Only reset or a low level on an armed wake pin ends power down.
// - Reset restarts oscillator and PLL and resets registers; RAM untouched.
// - Pin wake-up restarts clocks and keeps registers frozen at entry.
// - Setting bit 1 of power control enters power down.
// - Interrupt zero wakes only if enabled and selected before entry.
// - Wake pin low is latched and clocks start; pin may then rise.
// - Wait oscillator settling then PLL lock before resuming.
// - Resume raises wake interrupt at vector 007B, discarding call fetches.
// - After the interrupt return, execution continues after the entry sequence.
// - Other interrupts are blocked from wake pin fall until interrupt return.
// - Source select set makes the receive pin the wake trigger instead.
// - Wake enable is bit 0 of wake control and permits pin wake-up.
// - Source select 0 picks interrupt zero pin, 1 picks receive pin.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`default_nettype none

module pdw_top #(
    parameter int P_OSC_CYCLES = pdw_pkg::OSC_CYCLES,
    parameter int P_PLL_CYCLES = pdw_pkg::PLL_CYCLES
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // APB slave
    input wire pdw_pkg::pdw_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Wake-up pins
    input wire logic i_external_interrupt_zero_pin_pin,
    input wire logic i_rxd_pin,
    // Core side
    input wire logic [7:0] i_alt_value,
    input wire logic i_ale_core,
    input wire logic i_irq_ack,
    input wire logic i_interrupt_return_instruction,
    // Clock and freeze control
    output logic o_osc_en,
    output logic o_pll_en,
    output logic o_core_clk_en,
    output logic o_sfr_freeze,
    // Pins
    output logic [7:0] o_pin_out,
    output logic o_ale,
    // Wake-up interrupt
    output logic o_wake_irq,
    output logic [15:0] o_wake_vector,
    output logic o_fetch_discard,
    output logic o_irq_block
);

    localparam int CW = $clog2(P_OSC_CYCLES + P_PLL_CYCLES + 1);

    // ------------------------------------------------------------
    // Decoding function
    // ------------------------------------------------------------
    function automatic logic in_wake_phase(input pdw_pkg::pdw_state_t s);
        in_wake_phase = (s == pdw_pkg::ST_OSC_WAIT) || (s == pdw_pkg::ST_PLL_WAIT) ||
                        (s == pdw_pkg::ST_WAKE_IRQ) || (s == pdw_pkg::ST_WAKE_ISR);
    endfunction : in_wake_phase

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pdw_pkg::pdw_state_t state_q, state_d;
    logic [CW-1:0] wait_q, wait_d;
    logic [7:0] pctl_q, wctl_q, port_q, alt_sel_q, alt_hold_q;
    logic arm_en_q, arm_sel_q, wake_src_q;
    logic external_interrupt_zero_pin_meta_q, external_interrupt_zero_pin_sync_q, rxd_meta_q, rxd_sync_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_ph = i_apb.psel && !i_apb.penable;
    wire wr_fire = i_apb.psel && i_apb.penable && i_apb.pwrite && pready_q &&
                   (state_q == pdw_pkg::ST_RUN);
    wire hit_pctl = (i_apb.paddr == pdw_pkg::ADDR_PCTL);
    wire hit_wctl = (i_apb.paddr == pdw_pkg::ADDR_WCTL);
    wire hit_port = (i_apb.paddr == pdw_pkg::ADDR_PORT);
    wire hit_alt = (i_apb.paddr == pdw_pkg::ADDR_ALT);
    wire hit_stat = (i_apb.paddr == pdw_pkg::ADDR_STAT);
    wire hit_any = hit_pctl || hit_wctl || hit_port || hit_alt || hit_stat;
    wire [31:0] stat_word = {25'h0, wake_src_q, arm_sel_q, arm_en_q, 1'b0, state_q};
    wire [31:0] rd_data = hit_pctl ? {24'h0, pctl_q} :
                          hit_wctl ? {24'h0, wctl_q} :
                          hit_port ? {24'h0, port_q} :
                          hit_alt ? {24'h0, alt_sel_q} :
                          hit_stat ? stat_word : 32'h0;

    // ------------------------------------------------------------
    // Sequencer decode
    // ------------------------------------------------------------
    wire enter_pd = wr_fire && hit_pctl && i_apb.pwdata[pdw_pkg::PDE_BIT];
    // Pin high during power down is the source's duty; low requests wake
    wire external_interrupt_zero_pin_hit = arm_en_q && !arm_sel_q && !external_interrupt_zero_pin_sync_q;
    wire rxd_hit = arm_en_q && arm_sel_q && !rxd_sync_q;
    wire wake_hit = external_interrupt_zero_pin_hit || rxd_hit;
    wire wait_done = (wait_q == '0);

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        unique case (state_q)
            pdw_pkg::ST_RUN: begin
                if (enter_pd) begin
                    state_d = pdw_pkg::ST_PDOWN;
                end
            end
            pdw_pkg::ST_PDOWN: begin
                if (wake_hit) begin
                    state_d = pdw_pkg::ST_OSC_WAIT;
                    wait_d = CW'(P_OSC_CYCLES - 1);
                end
            end
            pdw_pkg::ST_OSC_WAIT: begin
                if (wait_done) begin
                    state_d = pdw_pkg::ST_PLL_WAIT;
                    wait_d = CW'(P_PLL_CYCLES - 1);
                end else begin
                    wait_d = wait_q - CW'(1);
                end
            end
            pdw_pkg::ST_PLL_WAIT: begin
                if (wait_done) begin
                    state_d = pdw_pkg::ST_WAKE_IRQ;
                end else begin
                    wait_d = wait_q - CW'(1);
                end
            end
            pdw_pkg::ST_WAKE_IRQ: begin
                if (i_irq_ack) begin
                    state_d = pdw_pkg::ST_WAKE_ISR;
                end
            end
            pdw_pkg::ST_WAKE_ISR: begin
                if (i_interrupt_return_instruction) begin
                    state_d = pdw_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = pdw_pkg::ST_RUN;
            end
        endcase
    end

    wire pd_next = (state_d == pdw_pkg::ST_PDOWN);
    wire clk_gate_next = (state_d == pdw_pkg::ST_RUN) || (state_d == pdw_pkg::ST_WAKE_IRQ) ||
                         (state_d == pdw_pkg::ST_WAKE_ISR);
    wire frozen_next = !clk_gate_next;
    wire pde_clear = (state_d == pdw_pkg::ST_WAKE_IRQ) && (state_q == pdw_pkg::ST_PLL_WAIT);
    wire [7:0] pctl_wr = i_apb.pwdata[7:0] & pdw_pkg::PCTL_MASK;
    wire [7:0] pctl_next = wr_fire && hit_pctl ? pctl_wr :
                           pde_clear ? (pctl_q & ~(8'h01 << pdw_pkg::PDE_BIT)) : pctl_q;
    wire ale_next = pd_next ? !wctl_q[pdw_pkg::ALE_OFF_BIT] : i_ale_core;

    // ------------------------------------------------------------
    // Pin output selection
    // ------------------------------------------------------------
    logic [7:0] pin_next;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            assign pin_next[gi] = alt_sel_q[gi] ? alt_hold_q[gi] : port_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Wake pin synchronisers
    // ------------------------------------------------------------
    // Level detect is combinational on the synced pin, no edge needed
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            external_interrupt_zero_pin_meta_q <= 1'b1;
            external_interrupt_zero_pin_sync_q <= 1'b1;
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
        end else if (i_clk_en) begin
            external_interrupt_zero_pin_meta_q <= i_external_interrupt_zero_pin_pin;
            external_interrupt_zero_pin_sync_q <= external_interrupt_zero_pin_meta_q;
            rxd_meta_q <= i_rxd_pin;
            rxd_sync_q <= rxd_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= pdw_pkg::ST_RUN;
            wait_q <= '0;
            arm_en_q <= 1'b0;
            arm_sel_q <= 1'b0;
            wake_src_q <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            wait_q <= wait_d;
            if (enter_pd) begin
                arm_en_q <= wctl_q[pdw_pkg::WAKE_EN_BIT];
                arm_sel_q <= wctl_q[pdw_pkg::SRC_SEL_BIT];
            end
            if (state_q == pdw_pkg::ST_PDOWN && wake_hit) begin
                wake_src_q <= rxd_hit;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Only reset or a bus write alters them, except that wake-up clears pctl_q bit 1
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pctl_q <= pdw_pkg::PCTL_RST;
            wctl_q <= pdw_pkg::WCTL_RST;
            port_q <= pdw_pkg::PORT_RST;
            alt_sel_q <= pdw_pkg::ALT_RST;
        end else if (i_clk_en) begin
            pctl_q <= pctl_next;
            if (wr_fire && hit_wctl) begin
                wctl_q <= i_apb.pwdata[7:0] & pdw_pkg::WCTL_MASK;
            end
            if (wr_fire && hit_port) begin
                port_q <= i_apb.pwdata[7:0];
            end
            if (wr_fire && hit_alt) begin
                alt_sel_q <= i_apb.pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (i_clk_en) begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !hit_any;
            prdata_q <= (setup_ph && !i_apb.pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Pin, clock and interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alt_hold_q <= 8'h00;
            o_pin_out <= pdw_pkg::PORT_RST;
            o_ale <= 1'b1;
            o_osc_en <= 1'b1;
            o_pll_en <= 1'b1;
            o_core_clk_en <= 1'b1;
            o_sfr_freeze <= 1'b0;
            o_wake_irq <= 1'b0;
            o_fetch_discard <= 1'b0;
            o_irq_block <= 1'b0;
            o_wake_vector <= pdw_pkg::WAKE_VECTOR;
        end else if (i_clk_en) begin
            if (state_q == pdw_pkg::ST_RUN && !enter_pd) begin
                alt_hold_q <= i_alt_value;
            end
            o_pin_out <= pin_next;
            o_ale <= ale_next;
            o_osc_en <= !pd_next;
            o_pll_en <= !pd_next;
            o_core_clk_en <= clk_gate_next;
            o_sfr_freeze <= frozen_next;
            o_wake_irq <= (state_d == pdw_pkg::ST_WAKE_IRQ);
            o_fetch_discard <= (state_d == pdw_pkg::ST_WAKE_IRQ);
            o_irq_block <= in_wake_phase(state_d);
            o_wake_vector <= pdw_pkg::WAKE_VECTOR;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk iff i_clk_en); endclocking
    default disable iff (i_sys_rst);

    sequence s_wake_start;
        state_q == pdw_pkg::ST_OSC_WAIT && o_osc_en && o_pll_en && !o_core_clk_en;
    endsequence

    chk_pde_enter: assert property (enter_pd |=> state_q == pdw_pkg::ST_PDOWN && !o_osc_en
        && !o_pll_en && !o_core_clk_en && o_sfr_freeze)
        else $error("power down not entered");
    chk_pin_hold: assert property ((state_q == pdw_pkg::ST_PDOWN) [*2] |-> $stable(o_pin_out))
        else $error("pin changed in power down");
    chk_ale_high: assert property (state_q == pdw_pkg::ST_PDOWN |-> o_ale ==
        !wctl_q[pdw_pkg::ALE_OFF_BIT])
        else $error("ale level wrong in power down");
    chk_stay_down: assert property (state_q == pdw_pkg::ST_PDOWN && !wake_hit
        |=> state_q == pdw_pkg::ST_PDOWN)
        else $error("power down left without cause");
    chk_external_interrupt_zero_pin_wake: assert property (state_q == pdw_pkg::ST_PDOWN && arm_en_q
        && !arm_sel_q && !external_interrupt_zero_pin_sync_q |=> s_wake_start ##0 !wake_src_q)
        else $error("interrupt zero wake failed");
    chk_rxd_wake: assert property (state_q == pdw_pkg::ST_PDOWN && arm_en_q
        && arm_sel_q && !rxd_sync_q |=> s_wake_start ##0 wake_src_q)
        else $error("receive pin wake failed");
    chk_osc_count: assert property (state_q == pdw_pkg::ST_OSC_WAIT && !wait_done
        |=> state_q == pdw_pkg::ST_OSC_WAIT && wait_q == $past(wait_q) - CW'(1))
        else $error("oscillator wait miscounted");
    chk_irq_vector: assert property (state_q == pdw_pkg::ST_PLL_WAIT && wait_done
        |=> o_wake_irq && o_fetch_discard && o_core_clk_en
        && o_wake_vector == pdw_pkg::WAKE_VECTOR && !pctl_q[pdw_pkg::PDE_BIT])
        else $error("wake interrupt not raised");
    chk_irq_block: assert property (in_wake_phase(state_q) |-> o_irq_block)
        else $error("interrupts not blocked");
    chk_resume: assert property (state_q == pdw_pkg::ST_WAKE_ISR && i_interrupt_return_instruction
        |=> state_q == pdw_pkg::ST_RUN && !o_irq_block && !o_wake_irq)
        else $error("no resume after return");
    chk_src_latch: assert property (in_wake_phase(state_q) && in_wake_phase($past(state_q))
        |-> $stable(wake_src_q))
        else $error("wake source latch changed");

endmodule : pdw_top

`default_nettype wire

/* sim/pdw_wake_src.sv */
// Purpose: Wake-up source model driving the interrupt zero and receive pins
// Assumes: Pulses start on a one-cycle fire request
// Notes:   Both pins idle high between wake requests
`default_nettype none

module pdw_wake_src (
    // Control
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic i_sel,
    input wire logic [3:0] i_len,
    // Pins
    output logic o_external_interrupt_zero_pin_pin,
    output logic o_rxd_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic sel_q = 1'b0;
    always @(posedge i_clk) begin
        if (i_fire) begin
            cnt <= i_len;
            sel_q <= i_sel;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Held high, pulled low only for a request
    assign o_external_interrupt_zero_pin_pin = !(cnt > 0 && !sel_q);
    assign o_rxd_pin = !(cnt > 0 && sel_q);
endmodule : pdw_wake_src

`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench of the power down wake-up controller
// Assumes: Short settling counts, zero wait APB answers
// Notes:   Expected values come from a small register model
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OSC = 8;
    localparam int PLL = 4;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    pdw_pkg::pdw_apb_req_t apb = '0;
    logic [7:0] alt_v = 8'h00;
    logic ale_core = 1'b0;
    logic irq_ack = 1'b0;
    logic interrupt_return_instruction = 1'b0;
    logic fire = 1'b0;
    logic sel = 1'b0;
    logic [3:0] plen = 4'h4;
    logic clk_en = 1'b1;
    int stat_m = 0;
    logic external_interrupt_zero_pin, rxd, pready, pslverr, osc_en, pll_en, core_en, freeze, ale;
    logic wake_irq, discard, blk;
    logic [31:0] prdata;
    logic [7:0] pin_out;
    logic [15:0] vec;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int regs_m [4];
    int n;
    logic [7:0] p;
    logic [7:0] held;

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    pdw_top #(.P_OSC_CYCLES(OSC), .P_PLL_CYCLES(PLL)) uut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en), .i_apb(apb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_external_interrupt_zero_pin_pin(external_interrupt_zero_pin), .i_rxd_pin(rxd), .i_alt_value(alt_v),
        .i_ale_core(ale_core), .i_irq_ack(irq_ack), .i_interrupt_return_instruction(interrupt_return_instruction),
        .o_osc_en(osc_en), .o_pll_en(pll_en), .o_core_clk_en(core_en),
        .o_sfr_freeze(freeze), .o_pin_out(pin_out), .o_ale(ale),
        .o_wake_irq(wake_irq), .o_wake_vector(vec), .o_fetch_discard(discard),
        .o_irq_block(blk));

    pdw_wake_src src (.i_clk(i_clk), .i_fire(fire), .i_sel(sel), .i_len(plen),
        .o_external_interrupt_zero_pin_pin(external_interrupt_zero_pin), .o_rxd_pin(rxd));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        @(negedge i_clk);
    endtask : tick

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic e);
        @(posedge i_clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apb <= '0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic run);
        logic [31:0] r;
        logic e;
        logic [7:0] m [4];
        m = '{pdw_pkg::PCTL_MASK, pdw_pkg::WCTL_MASK, 8'hFF, 8'hFF};
        xfer(1'b1, a, d, r, e);
        if (run) regs_m[a[3:2]] = int'(d & m[a[3:2]]);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 8'h00, r, e);
        if (a > 8'h10) begin
            `CHK(e, 1'b1)
            `CHK(r, 32'h0)
        end else begin
            `CHK(e, 1'b0)
            `CHK(r, (a == pdw_pkg::ADDR_STAT) ? 32'(stat_m) : 32'(regs_m[a[3:2]]))
        end
    endtask : rd

    task automatic pin_chk(input logic [7:0] h);
        logic [7:0] q;
        logic [7:0] m;
        q = 8'(regs_m[2]);
        m = 8'(regs_m[3]);
        `CHK(pin_out, (q & ~m) | (h & m))
    endtask : pin_chk

    task automatic do_reset();
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        regs_m = '{pdw_pkg::PCTL_RST, pdw_pkg::WCTL_RST, pdw_pkg::PORT_RST, pdw_pkg::ALT_RST};
        stat_m = 0;
        tick(1);
    endtask : do_reset

    task automatic pulse(input logic s, input logic [3:0] len);
        @(posedge i_clk);
        fire <= 1'b1;
        sel <= s;
        plen <= len;
        @(posedge i_clk);
        fire <= 1'b0;
    endtask : pulse

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(38));
        do_reset();
        `CHK(pin_out, 8'hFF)
        `CHK({osc_en, pll_en, core_en, freeze, ale}, {4'b1110, ale_core})
        for (int a = 0; a <= 20; a += 4) rd(8'(a));
        wr(pdw_pkg::ADDR_PORT, 8'($urandom), 1'b1);
        wr(pdw_pkg::ADDR_ALT, 8'($urandom), 1'b1);
        @(posedge i_clk);
        alt_v <= 8'($urandom);
        ale_core <= 1'($urandom);
        tick(3);
        pin_chk(alt_v);
        `CHK(ale, ale_core)
        @(posedge i_clk);
        clk_en <= 1'b0;
        ale_core <= ~ale_core;
        tick(3);
        `CHK(ale, ~ale_core)
        @(posedge i_clk);
        clk_en <= 1'b1;
        tick(2);
        `CHK(ale, ale_core)
        wr(pdw_pkg::ADDR_WCTL, 8'h00, 1'b1);
        wr(pdw_pkg::ADDR_PCTL, 8'h02, 1'b1);
        tick(2);
        `CHK({osc_en, pll_en, core_en, freeze}, 4'b0001)
        `CHK(ale, 1'b1)
        pulse(1'b0, 4'h5);
        tick(12);
        `CHK({osc_en, blk}, 2'b00)
        do_reset();
        `CHK({osc_en, pll_en, core_en, pin_out}, 11'h7FF)
        rd(pdw_pkg::ADDR_PCTL);
        for (int s = 0; s < 2; s++) begin
            wr(pdw_pkg::ADDR_WCTL, 8'(1 | (s << 1) | (s << 2)), 1'b1);
            p = 8'($urandom);
            wr(pdw_pkg::ADDR_PORT, p, 1'b1);
            wr(pdw_pkg::ADDR_ALT, 8'($urandom), 1'b1);
            held = alt_v;
            wr(pdw_pkg::ADDR_PCTL, 8'h02, 1'b1);
            @(posedge i_clk);
            alt_v <= ~held;
            tick(3);
            pin_chk(held);
            `CHK(ale, 1'(s == 0))
            wr(pdw_pkg::ADDR_PORT, ~p, 1'b0);
            stat_m = 'h11 | (s << 5);
            rd(pdw_pkg::ADDR_STAT);
            pulse(1'(s == 0), 4'h6);
            tick(12);
            `CHK({osc_en, blk}, 2'b00)
            pulse(1'(s), 4'(3 + $urandom % 4));
            n = 0;
            while (blk !== 1'b1 && n < 30) begin
                tick(1);
                n++;
            end
            `CHK({blk, osc_en, pll_en, core_en}, 4'b1110)
            n = 0;
            while (wake_irq !== 1'b1 && n < 100) begin
                tick(1);
                n++;
            end
            `CHK(1'(n >= OSC + PLL - 1 && n <= OSC + PLL + 1), 1'b1)
            `CHK({discard, core_en, freeze, vec}, {3'b110, 16'h007B})
            @(posedge i_clk);
            irq_ack <= 1'b1;
            @(posedge i_clk);
            irq_ack <= 1'b0;
            tick(1);
            `CHK({wake_irq, discard, blk}, 3'b001)
            @(posedge i_clk);
            interrupt_return_instruction <= 1'b1;
            @(posedge i_clk);
            interrupt_return_instruction <= 1'b0;
            tick(1);
            `CHK(blk, 1'b0)
            regs_m[0] = regs_m[0] & 'hFD;
            rd(pdw_pkg::ADDR_PCTL);
            rd(pdw_pkg::ADDR_PORT);
            rd(pdw_pkg::ADDR_WCTL);
            stat_m = 'h10 | (s << 5) | (s << 6);
            rd(pdw_pkg::ADDR_STAT);
            tick(3);
            pin_chk(alt_v);
        end
        conclude();
    end
endmodule : testbench

`default_nettype wire
